// ---- core/e1_tx_map.vh ----
// Constants for the E1 transmit pin interface
`ifndef E1_TX_MAP_VH
`define E1_TX_MAP_VH
`define ADDR_CONTROL_ONE 4'h0
`define ADDR_CONTROL_TWO 4'h1
`define ADDR_BLOCK_LO 4'h2
`define ADDR_BLOCK_HI 4'h3
`define ADDR_STATUS 4'h4
`define ADDR_LINE_DATA 4'h5
`define BIT_NRZ_OUT 7
`define BIT_STORE_EN 0
`define BIT_LOSS_OF_TX_CLOCK_EN 1
`define BIT_REMOTE_LOOP 2
`define BIT_SYNC_OUT 3
`define BIT_LINK_EN 4
`define BIT_SIG_EN 5
`define BIT_MF_SYNC 6
`define FLD_SA_LO 4
`define FLD_SA_HI 0
`define LOSS_OF_TX_CLOCK_TIME_NS 5000
`define CLK_PERIOD_NS 20
`define BITS_PER_FRAME 9'h100
`define FRAMES_PER_MF 4'h0010
`define SA_FIRST 3'h3
`define CHAN_LSB 3'h7
`endif

// ---- core/e1_tx_pins.v ----
// E1 transmit side pin interface with serial store, formatter and line mux
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ns
`include "e1_tx_map.vh"
module e1_tx_pins #(
    parameter CLK_NS = `CLK_PERIOD_NS
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [7:0] rdata,
    input wire tx_clock,
    input wire tx_system_clock,
    input wire tx_serial_data,
    input wire tx_signaling_in,
    input wire tx_link_data,
    output reg tx_link_clock,
    output reg tx_channel_clock,
    output reg tx_channel_block,
    input wire tx_sync_in,
    output reg tx_sync_out,
    output wire tx_sync_oe_n,
    input wire tx_system_sync,
    output reg tx_store_out,
    input wire tx_formatter_in,
    output reg tx_positive_out,
    output reg tx_negative_out,
    output wire tx_formatter_clock_out,
    input wire recovered_clock_out,
    input wire rx_framer_clock_in,
    input wire tx_positive_in,
    input wire tx_negative_in,
    input wire tx_line_clock_in,
    input wire line_interface_connect_strap,
    output reg line_pos,
    output reg line_neg,
    output reg loss_of_tx_clock
);

// ----------------------------------------------------------------
// Timing constants
// ----------------------------------------------------------------
localparam LOSS_OF_TX_CLOCK_CYC = `LOSS_OF_TX_CLOCK_TIME_NS / CLK_NS;

// Rounds an up-count target to at least one cycle
function [15:0] at_least_one;
    input integer v;
    begin
        at_least_one = (v < 1) ? 16'h0001 : v[15:0];
    end
endfunction

localparam [15:0] LOSS_OF_TX_CLOCK_LIMIT = at_least_one(LOSS_OF_TX_CLOCK_CYC);

// Falling edge of a sampled level, given its current and previous sample
function fell;
    input now_v;
    input old_v;
    begin
        fell = old_v & ~now_v;
    end
endfunction

// ----------------------------------------------------------------
// Operating notes
// ----------------------------------------------------------------
// Every pin is sampled by clk_sys, so pin clocks must stay well below
// a quarter of the system clock; a 2 MHz bit clock leaves ample room.
// A pin edge reaches the logic about three system cycles late, and
// registered outputs that follow pin clocks carry that latency; tx_formatter_clock_out is a cycle earlier.
// The elastic store is modelled as a straight path: with it enabled
// the system clock retimes the serial and signaling capture and the
// frame counter, and tx_system_sync sets the frame boundary.
// Bursty system clocks are accepted because only edges are counted,
// never periods.
// Clock loss is judged on synchronised tx_clock edges, both polarities, so a
// clock stuck high or stuck low is caught alike.
// The loss flag clears on the first edge after the clock returns;
// there is no hysteresis, so a marginal clock may flicker the flag.
// Remote loopback wins over loss substitution when both are set.
// The formatter clock output is a mux of synchronised clocks; it is
// meant for the loop-through pins, not for clocking other logic.
// The strap joins the line interface to the formatter; the external
// loop-through pins are then ignored and should be tied low.
// The NRZ output bit shares its place with the Sa7 enable, so NRZ
// output and Sa7 insertion always go together.
// Link bits fill timeslot 0 of odd frames only; the demand clock
// stays high across adjacent enabled Sa positions.
// Only the low byte of each half of the block mask is writable;
// channels 8 to 15 and 24 to 31 are never blocked.
// Line coding is plain AMI; no zero substitution is made.
// Unmapped register reads return zero, unmapped writes are dropped.

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg [7:0] tx_control_one;
reg [7:0] ctrl_two;
reg [31:0] block_mask;
wire store_en = ctrl_two[`BIT_STORE_EN];
wire loss_of_tx_clock_en = ctrl_two[`BIT_LOSS_OF_TX_CLOCK_EN];
wire remote_loop = ctrl_two[`BIT_REMOTE_LOOP];
wire sync_out_en = ctrl_two[`BIT_SYNC_OUT];
wire link_en = ctrl_two[`BIT_LINK_EN];
wire sig_en = ctrl_two[`BIT_SIG_EN];
wire mf_sync = ctrl_two[`BIT_MF_SYNC];
wire [4:0] sa_enable = {tx_control_one[`FLD_SA_HI], tx_control_one[`FLD_SA_LO +: 4]};

// Two-flop synchronisers for every pin; third stage for edges
reg [13:0] s1;
reg [13:0] s2;
reg [13:0] s3;
wire [13:0] raw = {tx_clock, tx_system_clock, tx_serial_data, tx_signaling_in,
    tx_link_data, tx_sync_in, tx_system_sync, tx_formatter_in, recovered_clock_out,
    rx_framer_clock_in, tx_positive_in, tx_negative_in, tx_line_clock_in,
    line_interface_connect_strap};
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        s1 <= 14'h0000;
        s2 <= 14'h0000;
        s3 <= 14'h0000;
    end else begin
        s1 <= raw;
        s2 <= s1;
        s3 <= s2;
    end
end
wire tx_clock_fall = fell(s2[13], s3[13]);
wire tx_clock_rise = ~s3[13] & s2[13];
wire sclk_fall = fell(s2[12], s3[12]);
wire ser_d = s2[11];
wire sig_d = s2[10];
wire link_d = s2[9];
wire sync_d = s2[8] & ~s3[8];
wire ssync_d = s2[7] & ~s3[7];
wire fmt_d = s2[6];
wire strap = s2[0];

// Domain clock edge: system clock with store on, else tx_clock
wire dom_fall = store_en ? sclk_fall : tx_clock_fall;

// ----------------------------------------------------------------
// Loss of transmit clock detector
// ----------------------------------------------------------------
reg [15:0] idle_cnt;
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        idle_cnt <= 16'h0000;
        loss_of_tx_clock <= 1'b0;
    end else if (tx_clock_fall | tx_clock_rise) begin
        idle_cnt <= 16'h0000;
        loss_of_tx_clock <= 1'b0;
    end else if (idle_cnt >= LOSS_OF_TX_CLOCK_LIMIT) begin
        loss_of_tx_clock <= 1'b1;
    end else begin
        idle_cnt <= idle_cnt + 16'h0001;
    end
end

// ----------------------------------------------------------------
// Formatter clock selection and line-interface join
// ----------------------------------------------------------------
wire loss_of_tx_clock_active = loss_of_tx_clock_en & loss_of_tx_clock;
wire fclk = remote_loop ? s2[4] : (loss_of_tx_clock_active ? s2[5] : s2[13]);
assign tx_formatter_clock_out = fclk;
reg fclk_q;
reg lclk_q;
wire lclk = strap ? fclk : s2[1];
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        fclk_q <= 1'b0;
        lclk_q <= 1'b0;
    end else begin
        fclk_q <= fclk;
        lclk_q <= lclk;
    end
end
wire fclk_rise = fclk & ~fclk_q;
wire fclk_fall = fell(fclk, fclk_q);
wire lclk_fall = fell(lclk, lclk_q);

// ----------------------------------------------------------------
// Frame counter in the selected domain
// ----------------------------------------------------------------
reg [7:0] bit_cnt;
reg [3:0] frame_cnt;
wire boundary = store_en ? ssync_d : (sync_d & ~sync_out_en);
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        bit_cnt <= 8'h00;
        frame_cnt <= 4'h0;
    end else if (boundary) begin
        bit_cnt <= 8'h00;
        frame_cnt <= 4'h0;
    end else if (dom_fall) begin
        bit_cnt <= bit_cnt + 8'h01;
        if (bit_cnt == 8'hff) frame_cnt <= frame_cnt + 4'h1;
    end
end
wire [4:0] chan = bit_cnt[7:3];
wire [2:0] bitpos = bit_cnt[2:0];

// Channel clock, channel block and sync pulse outputs
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        tx_channel_clock <= 1'b0;
        tx_channel_block <= 1'b0;
        tx_sync_out <= 1'b0;
    end else begin
        tx_channel_clock <= (bitpos == `CHAN_LSB);
        tx_channel_block <= block_mask[chan];
        tx_sync_out <= (bit_cnt == 8'h00) & (!mf_sync | frame_cnt == 4'h0);
    end
end
assign tx_sync_oe_n = ~sync_out_en;

// ----------------------------------------------------------------
// Serial and signaling capture, store output
// ----------------------------------------------------------------
reg ser_bit;
reg sig_bit;
reg [7:0] sig_cnt;
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        ser_bit <= 1'b0;
        sig_bit <= 1'b0;
        sig_cnt <= 8'h00;
        tx_store_out <= 1'b0;
    end else begin
        if (dom_fall) begin
            ser_bit <= ser_d;
            if (sig_en) begin
                sig_bit <= sig_d;
                sig_cnt <= sig_cnt + 8'h01;
            end
        end
        if (tx_clock_rise) tx_store_out <= ser_bit;
    end
end

// ----------------------------------------------------------------
// Link demand clock and link bit capture for Sa bits
// ----------------------------------------------------------------
wire odd_frame = frame_cnt[0];
wire [2:0] sa_idx = bitpos - `SA_FIRST;
wire sa_slot = odd_frame & (chan == 5'h00) & (bitpos >= `SA_FIRST);
wire sa_want = sa_slot & sa_enable[sa_idx];
reg link_bit;
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        tx_link_clock <= 1'b0;
        link_bit <= 1'b0;
    end else begin
        tx_link_clock <= link_en & sa_want;
        if (tx_clock_fall & link_en & sa_want) link_bit <= link_d;
    end
end

// ----------------------------------------------------------------
// Formatter: insert link bits, AMI encode, drive outputs
// ----------------------------------------------------------------
reg fmt_bit;
reg ami_flip;
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        fmt_bit <= 1'b0;
        ami_flip <= 1'b0;
        tx_positive_out <= 1'b0;
        tx_negative_out <= 1'b0;
    end else begin
        if (tx_clock_fall) fmt_bit <= (link_en & sa_want) ? link_bit : fmt_d;
        if (fclk_rise) begin
            if (tx_control_one[`BIT_NRZ_OUT]) begin
                tx_positive_out <= fmt_bit;
                tx_negative_out <= 1'b0;
            end else begin
                tx_positive_out <= fmt_bit & ~ami_flip;
                tx_negative_out <= fmt_bit & ami_flip;
                if (fmt_bit) ami_flip <= ~ami_flip;
            end
        end
    end
end

// Line-interface sampling, joined to formatter when strapped
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        line_pos <= 1'b0;
        line_neg <= 1'b0;
    end else if (lclk_fall) begin
        line_pos <= strap ? tx_positive_out : s2[3];
        line_neg <= strap ? tx_negative_out : s2[2];
    end
end

// ----------------------------------------------------------------
// Register port
// ----------------------------------------------------------------
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        tx_control_one <= 8'h00;
        ctrl_two <= 8'h00;
        block_mask <= 32'h0000_0000;
        rdata <= 8'h00;
    end else begin
        if (wr_stb) begin
            case (addr)
                `ADDR_CONTROL_ONE: tx_control_one <= wdata;
                `ADDR_CONTROL_TWO: ctrl_two <= wdata;
                `ADDR_BLOCK_LO: block_mask[15:0] <= {8'h00, wdata} | (block_mask[15:0] & 16'hff00);
                `ADDR_BLOCK_HI: block_mask[31:16] <= {8'h00, wdata} | (block_mask[31:16] & 16'hff00);
                default: ;
            endcase
        end
        if (rd_stb) begin
            case (addr)
                `ADDR_CONTROL_ONE: rdata <= tx_control_one;
                `ADDR_CONTROL_TWO: rdata <= ctrl_two;
                `ADDR_BLOCK_LO: rdata <= block_mask[7:0];
                `ADDR_BLOCK_HI: rdata <= block_mask[23:16];
                `ADDR_STATUS: rdata <= {5'h00, loss_of_tx_clock_active, loss_of_tx_clock, strap};
                `ADDR_LINE_DATA: rdata <= {6'h00, line_pos, line_neg};
                default: rdata <= 8'h00;
            endcase
        end
    end
end

endmodule

// ---- test/e1_tx_pins_monitor.sv ----
// Port checker for the E1 transmit pin interface
`timescale 1ns/1ns
module e1_tx_pins_monitor (
    input wire clk_sys,
    input wire rst_n,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    input wire [7:0] rdata,
    input wire tx_clock,
    input wire rx_framer_clock_in,
    input wire tx_sync_oe_n,
    input wire tx_store_out,
    input wire tx_positive_out,
    input wire tx_negative_out,
    input wire tx_formatter_clock_out,
    input wire loss_of_tx_clock
);
    reg [7:0] ctl;
    reg nrz;
    reg tq;
    reg rq;
    reg [5:0] st;
    reg [5:0] sr;
    reg [8:0] idle;
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    // Mirror control writes, time pin edges and idle spans
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctl <= 8'h00;
            nrz <= 1'b0;
            tq <= 1'b0;
            rq <= 1'b0;
            st <= 6'h00;
            sr <= 6'h00;
            idle <= 9'h000;
        end else begin
            if (wr_stb && addr == 4'h1) ctl <= wdata;
            if (wr_stb && addr == 4'h0) nrz <= wdata[7];
            tq <= tx_clock;
            rq <= rx_framer_clock_in;
            st <= (tx_clock && !tq) ? 6'h00 : ((st == 6'h3f) ? st : st + 6'h01);
            sr <= (rx_framer_clock_in && !rq) ? 6'h00 : ((sr == 6'h3f) ? sr : sr + 6'h01);
            idle <= (tx_clock != tq) ? 9'h000 : ((idle == 9'h1ff) ? idle : idle + 9'h001);
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_read_back: assert property (rd_stb && addr == 4'h1 |=> rdata == ctl)
        else $error("control read back differs");
    a_unmapped_zero: assert property (rd_stb && addr > 4'h5 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_sync_dir: assert property (tx_sync_oe_n == !ctl[3])
        else $error("sync pin direction wrong");
    a_ami_exclusive: assert property (!nrz |-> !(tx_positive_out && tx_negative_out))
        else $error("both bipolar outputs high");
    a_store_on_rise: assert property ($changed(tx_store_out) |-> st <= 6'h06)
        else $error("store output moved off rising edge");
    a_bipolar_on_rise: assert property ($changed(tx_positive_out) && ctl[2:1] == 2'b00
        && $past(ctl[2:1], 8) == 2'b00 |-> st <= 6'h06)
        else $error("positive output moved off rising edge");
    a_fmt_from_tx: assert property ($rose(tx_formatter_clock_out) && ctl[2:1] == 2'b00
        && $past(ctl[2:1], 4) == 2'b00 |-> st <= 6'h04)
        else $error("formatter clock not from tx clock");
    a_fmt_from_loop: assert property ($rose(tx_formatter_clock_out) && ctl[2]
        && $past(ctl[2], 4) |-> sr <= 6'h04)
        else $error("formatter clock not from framer clock");
    a_no_early_loss: assert property ($rose(loss_of_tx_clock) |-> idle >= 9'h0f0)
        else $error("clock loss flagged too early");
    a_loss_after_idle: assert property (idle == 9'h118 |-> loss_of_tx_clock)
        else $error("clock loss not flagged");
    c_loss: cover property ($rose(loss_of_tx_clock));
    c_loop: cover property (ctl[2] && $rose(tx_formatter_clock_out));
    c_unmapped: cover property (rd_stb && addr == 4'hf);
endmodule
bind e1_tx_pins e1_tx_pins_monitor mon (.clk_sys, .rst_n, .addr, .wdata, .wr_stb, .rd_stb,
    .rdata, .tx_clock, .rx_framer_clock_in, .tx_sync_oe_n, .tx_store_out, .tx_positive_out,
    .tx_negative_out, .tx_formatter_clock_out, .loss_of_tx_clock);

// ---- test/e1_tx_backplane.sv ----
// Backplane model driving the transmit serial pins
`timescale 1ns/1ns
module e1_tx_backplane (
    input wire run,
    output reg tx_clock,
    output wire tx_system_clock,
    output wire tx_system_sync,
    output reg tx_serial_data,
    output reg tx_signaling_in,
    output reg tx_link_data
);
    reg [3:0] cnt;
    // Bit clock runs unless stopped to provoke clock loss
    initial begin
        tx_clock = 1'b0;
        forever #80 if (run) tx_clock = ~tx_clock;
    end
    // Store unused, so its clock and sync stay low
    assign tx_system_clock = 1'b0;
    assign tx_system_sync = 1'b0;
    // Data moves on the rising edge, stable at the falling sample
    initial begin
        cnt = 4'h0;
        tx_serial_data = 1'b0;
        tx_signaling_in = 1'b0;
        tx_link_data = 1'b0;
        forever begin
            @(posedge tx_clock);
            cnt = cnt + 4'h1;
            tx_serial_data = cnt[0] ^ cnt[3];
            tx_signaling_in = cnt[2];
            tx_link_data = cnt[1];
        end
    end
endmodule

// ---- test/e1_tx_pins_test.sv ----
// Self-checking bench for the E1 transmit pin interface
`timescale 1ns/1ns
`define CHK(n, g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module e1_tx_pins_test;
    reg clk_sys = 1'b0;
    reg rst_n = 1'b0;
    reg [3:0] addr = 4'h0;
    reg [7:0] wdata = 8'h00;
    reg wr_stb = 1'b0;
    reg rd_stb = 1'b0;
    reg run = 1'b1;
    reg rx_framer_clock_in = 1'b0;
    reg recovered_clock_out = 1'b0;
    reg tx_positive_in = 1'b0;
    reg tx_negative_in = 1'b0;
    reg tx_line_clock_in = 1'b0;
    reg line_interface_connect_strap = 1'b0;
    integer err_total = 0;
    integer checked = 0;
    integer c;
    wire [7:0] rdata;
    wire [4:0] obs;
    wire tx_clock, tx_system_clock, tx_system_sync, tx_serial_data, tx_signaling_in;
    wire tx_link_data, tx_link_clock, tx_channel_clock, tx_channel_block, tx_sync_in;
    wire tx_sync_out, tx_sync_oe_n, tx_store_out, tx_formatter_in, tx_positive_out;
    wire tx_negative_out, tx_formatter_clock_out, line_pos, line_neg, loss_of_tx_clock;
    // Sync pin level, formatter loop wire and watched outputs
    assign tx_sync_in = tx_sync_oe_n ? 1'b0 : tx_sync_out;
    assign tx_formatter_in = tx_store_out;
    assign obs = {tx_formatter_clock_out, tx_link_clock, tx_channel_block, tx_channel_clock,
        line_pos};
    e1_tx_backplane bp (.run(run), .tx_clock, .tx_system_clock, .tx_system_sync,
        .tx_serial_data, .tx_signaling_in, .tx_link_data);
    e1_tx_pins #(.CLK_NS(20)) dut (.clk_sys, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
        .tx_clock, .tx_system_clock, .tx_serial_data, .tx_signaling_in, .tx_link_data,
        .tx_link_clock, .tx_channel_clock, .tx_channel_block, .tx_sync_in, .tx_sync_out,
        .tx_sync_oe_n, .tx_system_sync, .tx_store_out, .tx_formatter_in, .tx_positive_out,
        .tx_negative_out, .tx_formatter_clock_out, .recovered_clock_out, .rx_framer_clock_in,
        .tx_positive_in, .tx_negative_in, .tx_line_clock_in, .line_interface_connect_strap,
        .line_pos, .line_neg, .loss_of_tx_clock);
    // System and receive side clocks
    initial forever #10 clk_sys = ~clk_sys;
    initial forever #100 rx_framer_clock_in = ~rx_framer_clock_in;
    initial forever #120 recovered_clock_out = ~recovered_clock_out;
    // ------------------------------------------------------------
    // Bus and watch tasks
    // ------------------------------------------------------------
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            addr <= a;
            wdata <= d;
            wr_stb <= 1'b1;
            @(posedge clk_sys);
            wr_stb <= 1'b0;
            #1;
        end
    endtask
    task rdchk(input [3:0] a, input [7:0] e, input [8*8-1:0] n);
        begin
            @(posedge clk_sys);
            addr <= a;
            rd_stb <= 1'b1;
            @(posedge clk_sys);
            rd_stb <= 1'b0;
            #1;
            `CHK(n, rdata, e)
        end
    endtask
    task watch(input integer sel, input integer n, output integer r);
        reg prev;
        begin
            r = 0;
            prev = obs[sel];
            repeat (n) begin
                @(posedge clk_sys);
                #1;
                if (obs[sel] === 1'b1 && prev === 1'b0) r = r + 1;
                prev = obs[sel];
            end
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        begin
            `CHK("oe_n", tx_sync_oe_n, 1'b1)
            `CHK("loss", loss_of_tx_clock, 1'b0)
            `CHK("bipolar", {tx_positive_out, tx_negative_out}, 2'b00)
            $display("test reset done");
        end
    endtask
    task t_regs;
        reg [7:0] v;
        begin
            for (v = 8'h01; v != 8'h80; v = v << 1) begin
                wr(4'h1, v);
                rdchk(4'h1, v, "control");
            end
            wr(4'h1, 8'h08);
            `CHK("oe_n on", tx_sync_oe_n, 1'b0)
            rdchk(4'hf, 8'h00, "unmapped");
            wr(4'h1, 8'h00);
            `CHK("oe_n off", tx_sync_oe_n, 1'b1)
            $display("test registers done");
        end
    endtask
    task t_chan;
        begin
            watch(1, 512, c);
            `CHK("chan clk", c, 8)
            wr(4'h2, 8'h00);
            wr(4'h3, 8'h00);
            watch(2, 2100, c);
            `CHK("block off", c, 0)
            wr(4'h2, 8'hff);
            wr(4'h3, 8'hff);
            watch(2, 2100, c);
            `CHK("block on", c > 0, 1'b1)
            $display("test channel done");
        end
    endtask
    task t_link;
        begin
            wr(4'h0, 8'h00);
            wr(4'h1, 8'h10);
            watch(3, 4200, c);
            `CHK("link idle", c, 0)
            wr(4'h0, 8'h71);
            watch(3, 8400, c);
            `CHK("link demand", c >= 4, 1'b1)
            wr(4'h0, 8'h00);
            wr(4'h1, 8'h00);
            $display("test link done");
        end
    endtask
    task t_loop;
        integer j;
        begin
            for (j = 0; j < 3; j++) begin
                @(posedge clk_sys);
                {tx_positive_in, tx_negative_in} <= 2'b10 >> j;
                tx_line_clock_in <= 1'b1;
                repeat (8) @(posedge clk_sys);
                tx_line_clock_in <= 1'b0;
                repeat (8) @(posedge clk_sys);
                #1;
                `CHK("line out", {line_pos, line_neg}, 2'b10 >> j)
            end
            line_interface_connect_strap <= 1'b1;
            watch(0, 600, c);
            `CHK("strap join", c > 0, 1'b1)
            wr(4'h1, 8'h04);
            repeat (400) @(posedge clk_sys);
            wr(4'h1, 8'h00);
            line_interface_connect_strap <= 1'b0;
            $display("test loop done");
        end
    endtask
    task t_loss;
        begin
            wr(4'h1, 8'h02);
            run <= 1'b0;
            repeat (300) @(posedge clk_sys);
            #1;
            `CHK("loss", loss_of_tx_clock, 1'b1)
            rdchk(4'h4, 8'h06, "status");
            watch(4, 200, c);
            `CHK("substitute clock", c > 0, 1'b1)
            run <= 1'b1;
            repeat (300) @(posedge clk_sys);
            wr(4'h1, 8'h00);
            $display("test loss done");
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", checked, err_total);
            if (err_total == 0 && checked > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    // Watchdog against a hung run
    initial begin
        #1_500_000;
        err_total++;
        give_verdict;
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        t_reset;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs;
        t_chan;
        t_link;
        t_loop;
        t_loss;
        give_verdict;
    end
endmodule
